//--- rtl/smas_device_end.sv
// Superframe timing and medium-access scheduler of the local MAC entity
`timescale 1ns/1ps
`default_nettype none
module smas_device_end
  import smas_pkg::*;
#(
  parameter int unsigned SLOT_DURATION_NS = 256000
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       enable,
  input  wire smas_mode_t mode,
  input  wire logic       promote,
  input  wire logic [3:0] chan_sel,
  input  wire logic       incumbent,
  input  wire logic [7:0] beacon_slots,
  input  wire logic [7:0] own_slot,
  input  wire logic [7:0] rsw_slots,
  input  wire logic [7:0] csw_slots,
  input  wire logic [7:0] quiet_start,
  input  wire logic [7:0] quiet_len,
  input  wire logic [7:0] resv_start,
  input  wire logic [7:0] resv_len,
  input  wire logic       resv_member,
  input  wire logic       sleep_req,
  input  wire logic       tx_req,
  input  wire logic       bar_req,
  input  wire logic [11:0] tx_seq,
  input  wire logic [3:0] tx_frag,
  input  wire smas_ackp_t tx_ackp,
  input  wire logic [2:0] tx_rate,
  input  wire logic [2:0] tx_prio,
  input  wire logic [3:0] retry_max,
  output logic [7:0]      slot_num,
  output logic            sf_start,
  output logic            in_bw,
  output logic            in_rsw,
  output logic            in_dtw,
  output logic            in_csw,
  output logic            rx_on,
  output logic            synced,
  output logic            tx_accept,
  output logic            tx_done,
  output logic            tx_fail,
  output logic [7:0]      back_bmap,
  smas_if.dev             lnk
);
  localparam int unsigned SLOT_CYCLES =
    (SLOT_DURATION_NS / CLK_PERIOD_NS < 1) ? 1 : SLOT_DURATION_NS / CLK_PERIOD_NS;

  smas_sched_t sc_reg;
  smas_tx_t    tx_reg;
  logic [31:0] div_reg;
  logic [7:0]  slot_reg;
  logic        new_slot_reg;
  logic        sf_start_reg;
  logic [3:0]  chan_reg;
  logic        alien_vld_reg;
  logic [7:0]  alien_st_reg;
  logic [7:0]  bo_reg;
  logic [15:0] wait_reg;
  logic [3:0]  tries_reg;
  logic        is_bar_reg;
  logic [11:0] seq_reg;
  logic [3:0]  frag_reg;
  smas_ackp_t  ackp_reg;
  logic [2:0]  rate_reg;
  logic        slot_tick, run, beaconing, bcn_seen, bcn_fire;
  logic [7:0]  bp_len;
  logic        quiet, in_resv, in_alien, allowed, send, ack_ok, resp_ok;

  assign slot_tick = (div_reg == SLOT_CYCLES - 1);
  assign run       = (sc_reg == SMAS_SC_RUN);
  // A zero count still keeps one slot for the master's own beacon
  assign bp_len    = (beacon_slots == SLOT_ZERO) ? MIN_BP_SLOTS : beacon_slots;
  assign in_bw     = slot_reg < bp_len;
  assign in_rsw    = (mode != SMAS_MODE_PEER)
                     && smas_in_range(slot_reg, bp_len, rsw_slots);
  assign in_csw    = ({1'b0, slot_reg} + {1'b0, csw_slots}) > {1'b0, LAST_SLOT};
  assign in_dtw    = !in_bw && !in_rsw && !in_csw;
  assign quiet     = smas_in_range(slot_reg, quiet_start, quiet_len);
  assign in_resv   = smas_in_range(slot_reg, resv_start, resv_len);
  assign in_alien  = alien_vld_reg && smas_in_range(slot_reg, alien_st_reg, bp_len);
  assign beaconing = (mode != SMAS_MODE_SLAVE) || promote;
  assign bcn_seen  = lnk.f_valid && (lnk.f_kind == SMAS_K_BEACON)
                     && (lnk.f_chan == chan_reg)
                     && ((mode != SMAS_MODE_SLAVE) || lnk.f_master);
  assign bcn_fire  = run && beaconing && new_slot_reg && in_bw
                     && (slot_reg == own_slot) && !quiet;
  // Data only in the data window, never in a foreign beacon window or quiet period
  assign allowed   = run && in_dtw && !in_alien && !quiet
                     && (!in_resv || resv_member);
  assign send      = (tx_reg == SMAS_TX_WAIT) && allowed && !bcn_fire
                     && ((in_resv && resv_member) || bo_reg == SLOT_ZERO);
  assign resp_ok   = lnk.f_valid && (lnk.f_kind == SMAS_K_ACK) && (lnk.f_seq == seq_reg)
                     && (lnk.f_chan == chan_reg);
  assign ack_ok    = (tx_reg == SMAS_TX_ACK || tx_reg == SMAS_TX_BAR) && resp_ok;
  assign rx_on     = (sc_reg == SMAS_SC_SCAN) || !sleep_req || in_bw || in_csw;
  assign slot_num  = slot_reg;
  assign sf_start  = sf_start_reg;
  assign synced    = run;
  assign tx_accept = (tx_reg == SMAS_TX_IDLE) && run && (tx_req || bar_req);
  assign lnk.d_rx_on = rx_on;

  // Slot timing; an adopted beacon restarts the count at the sender's slot
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_reg      <= '0;
      slot_reg     <= SLOT_ZERO;
      new_slot_reg <= 1'b0;
      sf_start_reg <= 1'b0;
    end else if (sc_reg == SMAS_SC_SCAN && bcn_seen) begin
      div_reg      <= 32'd1;
      slot_reg     <= lnk.f_slot;
      new_slot_reg <= 1'b0;
      sf_start_reg <= 1'b0;
    end else begin
      new_slot_reg <= slot_tick;
      sf_start_reg <= slot_tick && (slot_reg == LAST_SLOT);
      div_reg      <= slot_tick ? '0 : div_reg + 32'd1;
      if (slot_tick) begin
        slot_reg <= slot_reg + 8'd1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sc_reg   <= SMAS_SC_IDLE;
      chan_reg <= 4'h0;
    end else if (!enable) begin
      sc_reg <= SMAS_SC_IDLE;
    end else begin
      case (sc_reg)
        SMAS_SC_IDLE: begin
          chan_reg <= chan_sel;
          sc_reg   <= SMAS_SC_SCAN;
        end
        SMAS_SC_SCAN: begin
          if (bcn_seen) begin
            sc_reg <= SMAS_SC_RUN;
          end else if (sf_start_reg && !incumbent && mode != SMAS_MODE_SLAVE) begin
            sc_reg <= SMAS_SC_RUN;
          end
        end
        SMAS_SC_RUN: sc_reg <= SMAS_SC_RUN;
        default: sc_reg <= SMAS_SC_IDLE;
      endcase
    end
  end

  // A beacon heard off our own slot grid marks a foreign beacon window
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      alien_vld_reg <= 1'b0;
      alien_st_reg  <= SLOT_ZERO;
    end else if (!run) begin
      alien_vld_reg <= 1'b0;
    end else if (bcn_seen && lnk.f_slot != slot_reg) begin
      alien_vld_reg <= 1'b1;
      alien_st_reg  <= slot_reg;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_reg     <= SMAS_TX_IDLE;
      bo_reg     <= SLOT_ZERO;
      wait_reg   <= '0;
      tries_reg  <= 4'h0;
      is_bar_reg <= 1'b0;
      seq_reg    <= '0;
      frag_reg   <= 4'h0;
      ackp_reg   <= SMAS_ACK_NONE;
      rate_reg   <= 3'h0;
      back_bmap  <= BMAP_ZERO;
    end else begin
      if (tx_reg == SMAS_TX_WAIT && !(in_resv && resv_member)) begin
        // Busy medium restarts the priority backoff
        if (lnk.f_valid) begin
          bo_reg <= PCA_BASE + PCA_STEP * {5'h00, tx_prio};
        end else if (allowed && bo_reg != SLOT_ZERO) begin
          bo_reg <= bo_reg - 8'd1;
        end
      end
      if (wait_reg != 16'h0000) begin
        wait_reg <= wait_reg - 16'd1;
      end
      case (tx_reg)
        SMAS_TX_IDLE: begin
          if (tx_accept) begin
            is_bar_reg <= bar_req;
            seq_reg    <= tx_seq;
            frag_reg   <= tx_frag;
            ackp_reg   <= tx_ackp;
            rate_reg   <= tx_rate;
            tries_reg  <= 4'h0;
            bo_reg     <= PCA_BASE + PCA_STEP * {5'h00, tx_prio};
            tx_reg     <= SMAS_TX_WAIT;
          end
        end
        SMAS_TX_WAIT: begin
          if (send) begin
            wait_reg <= ACK_WAIT_CYCLES;
            if (is_bar_reg) begin
              tx_reg <= SMAS_TX_BAR;
            end else if (ackp_reg == SMAS_ACK_IMM) begin
              tx_reg <= SMAS_TX_ACK;
            end else begin
              tx_reg <= SMAS_TX_IDLE;
            end
          end
        end
        SMAS_TX_ACK, SMAS_TX_BAR: begin
          if (ack_ok) begin
            if (tx_reg == SMAS_TX_BAR) begin
              back_bmap <= lnk.f_bmap;
            end
            tx_reg <= SMAS_TX_IDLE;
          end else if (wait_reg == 16'h0000) begin
            // Retry up to the limit, then the frame is discarded
            if (tries_reg + 4'd1 >= retry_max) begin
              tx_reg <= SMAS_TX_IDLE;
            end else begin
              tries_reg <= tries_reg + 4'd1;
              bo_reg    <= PCA_BASE + PCA_STEP * {5'h00, tx_prio};
              tx_reg    <= SMAS_TX_WAIT;
            end
          end
        end
        default: tx_reg <= SMAS_TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_done <= 1'b0;
      tx_fail <= 1'b0;
    end else begin
      tx_done <= ack_ok || (send && !is_bar_reg && ackp_reg != SMAS_ACK_IMM);
      tx_fail <= (tx_reg == SMAS_TX_ACK || tx_reg == SMAS_TX_BAR) && !ack_ok
                 && (wait_reg == 16'h0000) && (tries_reg + 4'd1 >= retry_max);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lnk.d_valid   <= 1'b0;
      lnk.d_kind    <= SMAS_K_BEACON;
      lnk.d_chan    <= 4'h0;
      lnk.d_slot    <= SLOT_ZERO;
      lnk.d_seq     <= '0;
      lnk.d_frag    <= 4'h0;
      lnk.d_ackp    <= SMAS_ACK_NONE;
      lnk.d_hrate   <= ROBUST_HDR_RATE;
      lnk.d_prate   <= BEACON_PAYLOAD_RATE;
      lnk.d_rsv_st  <= SLOT_ZERO;
      lnk.d_rsv_len <= SLOT_ZERO;
    end else begin
      lnk.d_valid   <= bcn_fire || send;
      lnk.d_kind    <= bcn_fire ? SMAS_K_BEACON : (is_bar_reg ? SMAS_K_BAR : SMAS_K_DATA);
      lnk.d_chan    <= chan_reg;
      lnk.d_slot    <= slot_reg;
      lnk.d_seq     <= seq_reg;
      lnk.d_frag    <= frag_reg;
      lnk.d_ackp    <= ackp_reg;
      lnk.d_hrate   <= ROBUST_HDR_RATE;
      lnk.d_prate   <= bcn_fire ? BEACON_PAYLOAD_RATE : rate_reg;
      lnk.d_rsv_st  <= alien_st_reg;
      lnk.d_rsv_len <= alien_vld_reg ? bp_len : SLOT_ZERO;
    end
  end
endmodule
`default_nettype wire

//--- rtl/smas_far_end.sv
// Far MAC entity: beacons in its own slot, answers immediate-ack data and block-ack requests with acknowledgements
`timescale 1ns/1ps
`default_nettype none
module smas_far_end
  import smas_pkg::*;
#(
  parameter int unsigned SLOT_DURATION_NS = 256000
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       enable,
  input  wire logic [3:0] chan,
  input  wire logic       is_master,
  input  wire logic       beacon_en,
  input  wire logic [7:0] own_slot,
  input  wire logic [7:0] bp_len,
  input  wire logic [7:0] csw_slots,
  input  wire logic [7:0] quiet_start,
  input  wire logic [7:0] quiet_len,
  input  wire logic       sleep_req,
  output logic [7:0]      slot_num,
  output logic            rx_data,
  output logic [11:0]     rx_seq,
  output logic [3:0]      rx_frag,
  smas_if.far             lnk
);
  localparam int unsigned SLOT_CYCLES =
    (SLOT_DURATION_NS / CLK_PERIOD_NS < 1) ? 1 : SLOT_DURATION_NS / CLK_PERIOD_NS;

  logic [31:0] div_reg;
  logic [7:0]  slot_reg;
  logic        new_slot_reg;
  logic        slot_tick;
  logic        in_bp, in_csw, quiet, rx_on, dev_ok, bcn_fire;
  logic        ack_pend_reg, bar_pend_reg;
  logic [7:0]  sifs_reg;
  logic [11:0] ack_seq_reg;
  logic [7:0]  bmap_reg;
  logic        resp_go;

  assign slot_tick = (div_reg == SLOT_CYCLES - 1);
  assign in_bp     = slot_reg < bp_len;
  assign in_csw    = ({1'b0, slot_reg} + {1'b0, csw_slots}) > {1'b0, LAST_SLOT};
  assign quiet     = smas_in_range(slot_reg, quiet_start, quiet_len);
  assign rx_on     = enable && (!sleep_req || in_bp || in_csw);
  assign dev_ok    = lnk.d_valid && rx_on && (lnk.d_chan == chan);
  assign bcn_fire  = enable && beacon_en && new_slot_reg && in_bp
                     && (slot_reg == own_slot) && !quiet;
  // Answers wait out beacon windows and quiet periods
  assign resp_go   = (ack_pend_reg || bar_pend_reg) && (sifs_reg == SLOT_ZERO)
                     && !in_bp && !quiet && !bcn_fire;
  assign slot_num  = slot_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_reg      <= '0;
      slot_reg     <= SLOT_ZERO;
      new_slot_reg <= 1'b0;
    end else if (dev_ok && lnk.d_kind == SMAS_K_BEACON) begin
      div_reg      <= 32'd1;
      slot_reg     <= lnk.d_slot;
      new_slot_reg <= 1'b0;
    end else begin
      new_slot_reg <= slot_tick;
      div_reg      <= slot_tick ? '0 : div_reg + 32'd1;
      if (slot_tick) begin
        slot_reg <= slot_reg + 8'd1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_pend_reg <= 1'b0;
      bar_pend_reg <= 1'b0;
      sifs_reg     <= SLOT_ZERO;
      ack_seq_reg  <= '0;
      bmap_reg     <= BMAP_ZERO;
    end else begin
      if (sifs_reg != SLOT_ZERO) begin
        sifs_reg <= sifs_reg - 8'd1;
      end
      if (resp_go) begin
        ack_pend_reg <= 1'b0;
        bar_pend_reg <= 1'b0;
        if (bar_pend_reg) begin
          bmap_reg <= BMAP_ZERO;
        end
      end
      if (dev_ok && lnk.d_kind == SMAS_K_DATA) begin
        if (lnk.d_ackp == SMAS_ACK_IMM) begin
          ack_pend_reg <= 1'b1;
          ack_seq_reg  <= lnk.d_seq;
          sifs_reg     <= SIFS_CYCLES;
        end else if (lnk.d_ackp == SMAS_ACK_BLOCK) begin
          bmap_reg[lnk.d_seq[2:0]] <= 1'b1;
        end
      end else if (dev_ok && lnk.d_kind == SMAS_K_BAR) begin
        bar_pend_reg <= 1'b1;
        ack_seq_reg  <= lnk.d_seq;
        sifs_reg     <= SIFS_CYCLES;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lnk.f_valid  <= 1'b0;
      lnk.f_kind   <= SMAS_K_BEACON;
      lnk.f_chan   <= 4'h0;
      lnk.f_slot   <= SLOT_ZERO;
      lnk.f_seq    <= '0;
      lnk.f_master <= 1'b0;
      lnk.f_bmap   <= BMAP_ZERO;
      rx_data      <= 1'b0;
      rx_seq       <= '0;
      rx_frag      <= 4'h0;
    end else begin
      lnk.f_valid  <= bcn_fire || resp_go;
      lnk.f_kind   <= bcn_fire ? SMAS_K_BEACON : SMAS_K_ACK;
      lnk.f_chan   <= chan;
      lnk.f_slot   <= slot_reg;
      lnk.f_seq    <= ack_seq_reg;
      lnk.f_master <= is_master;
      lnk.f_bmap   <= bar_pend_reg ? bmap_reg : BMAP_ZERO;
      rx_data      <= dev_ok && lnk.d_kind == SMAS_K_DATA;
      if (dev_ok && lnk.d_kind == SMAS_K_DATA) begin
        rx_seq  <= lnk.d_seq;
        rx_frag <= lnk.d_frag;
      end
    end
  end

  assign lnk.f_rx_on = rx_on;
endmodule
`default_nettype wire

//--- rtl/smas_if.sv
// Shared radio channel between the scheduler and a far MAC entity
`timescale 1ns/1ps
`default_nettype none
interface smas_if;
  import smas_pkg::*;
  logic        d_valid;
  smas_kind_t  d_kind;
  logic [3:0]  d_chan;
  logic [7:0]  d_slot;
  logic [11:0] d_seq;
  logic [3:0]  d_frag;
  smas_ackp_t  d_ackp;
  logic [2:0]  d_hrate;
  logic [2:0]  d_prate;
  logic [7:0]  d_rsv_st;
  logic [7:0]  d_rsv_len;
  logic        d_rx_on;
  logic        f_valid;
  smas_kind_t  f_kind;
  logic [3:0]  f_chan;
  logic [7:0]  f_slot;
  logic [11:0] f_seq;
  logic        f_master;
  logic [7:0]  f_bmap;
  logic        f_rx_on;
  modport dev (output d_valid, d_kind, d_chan, d_slot, d_seq, d_frag, d_ackp, d_hrate,
               d_prate, d_rsv_st, d_rsv_len, d_rx_on,
               input f_valid, f_kind, f_chan, f_slot, f_seq, f_master, f_bmap, f_rx_on);
  modport far (input d_valid, d_kind, d_chan, d_slot, d_seq, d_frag, d_ackp, d_hrate,
               d_prate, d_rsv_st, d_rsv_len, d_rx_on,
               output f_valid, f_kind, f_chan, f_slot, f_seq, f_master, f_bmap, f_rx_on);
endinterface
`default_nettype wire

//--- rtl/smas_pkg.sv
// Shared constants, types and decoding for the superframe scheduler link
package smas_pkg;
  localparam int unsigned CLK_PERIOD_NS    = 10;
  localparam int unsigned SLOT_COUNT       = 256;
  localparam logic [7:0]  LAST_SLOT        = 8'hff;
  localparam logic [7:0]  SLOT_ZERO        = 8'h00;
  localparam logic [7:0]  MIN_BP_SLOTS     = 8'h01;
  localparam logic [15:0] ACK_WAIT_CYCLES  = 16'h00c8;
  localparam logic [7:0]  SIFS_CYCLES      = 8'h0a;
  localparam logic [7:0]  PCA_BASE         = 8'h04;
  localparam logic [7:0]  PCA_STEP         = 8'h02;
  localparam logic [2:0]  BEACON_PAYLOAD_RATE = 3'h0;
  localparam logic [2:0]  ROBUST_HDR_RATE  = 3'h0;
  localparam logic [7:0]  BMAP_ZERO        = 8'h00;

  typedef enum logic [1:0] {
    SMAS_MODE_PEER   = 2'b00,
    SMAS_MODE_MASTER = 2'b01,
    SMAS_MODE_SLAVE  = 2'b10
  } smas_mode_t;

  typedef enum logic [1:0] {
    SMAS_K_BEACON = 2'b00,
    SMAS_K_DATA   = 2'b01,
    SMAS_K_ACK    = 2'b10,
    SMAS_K_BAR    = 2'b11
  } smas_kind_t;

  typedef enum logic [1:0] {
    SMAS_ACK_NONE  = 2'b00,
    SMAS_ACK_IMM   = 2'b01,
    SMAS_ACK_BLOCK = 2'b10
  } smas_ackp_t;

  typedef enum logic [1:0] {
    SMAS_SC_IDLE = 2'b00,
    SMAS_SC_SCAN = 2'b01,
    SMAS_SC_RUN  = 2'b10
  } smas_sched_t;

  typedef enum logic [2:0] {
    SMAS_TX_IDLE = 3'b000,
    SMAS_TX_WAIT = 3'b001,
    SMAS_TX_ACK  = 3'b010,
    SMAS_TX_BAR  = 3'b011
  } smas_tx_t;

  // Slot s lies in the wrapping window [st, st+len)
  function automatic logic smas_in_range(input logic [7:0] s, input logic [7:0] st,
                                         input logic [7:0] len);
    logic [7:0] d;
    d = s - st;
    return (len != SLOT_ZERO) && (d < len);
  endfunction
endpackage

//--- tb/smas_properties.sv
// Checker for the link between the two scheduler ends
`timescale 1ns/1ps
`default_nettype none
module smas_properties
  import smas_pkg::*;
(
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [7:0]  bw_len,
  input wire logic [7:0]  q_start,
  input wire logic [7:0]  q_len,
  input wire logic [7:0]  r_start,
  input wire logic [7:0]  r_len,
  input wire logic [3:0]  chan,
  input wire logic        d_valid,
  input wire smas_kind_t  d_kind,
  input wire logic [3:0]  d_chan,
  input wire logic [7:0]  d_slot,
  input wire logic [11:0] d_seq,
  input wire smas_ackp_t  d_ackp,
  input wire logic [2:0]  d_hrate,
  input wire logic [2:0]  d_prate,
  input wire logic        d_rx_on,
  input wire logic        f_valid,
  input wire smas_kind_t  f_kind,
  input wire logic [7:0]  f_slot,
  input wire logic [11:0] f_seq,
  input wire logic        f_rx_on
);
  logic [11:0] imm_seq_reg;
  // Acks arrive many cycles after their frame, so the asked sequence is held
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      imm_seq_reg <= 12'h000;
    end else if (d_valid && (d_kind == SMAS_K_BAR
                 || (d_kind == SMAS_K_DATA && d_ackp == SMAS_ACK_IMM))) begin
      imm_seq_reg <= d_seq;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_dbcn;
    d_valid && d_kind == SMAS_K_BEACON;
  endsequence
  sequence s_ddata;
    d_valid && d_kind != SMAS_K_BEACON;
  endsequence
  a_beacon_rate: assert property (s_dbcn |-> d_prate == BEACON_PAYLOAD_RATE)
    else $error("beacon payload rate");
  a_header_rate: assert property (d_valid |-> d_hrate == ROBUST_HDR_RATE)
    else $error("header rate");
  a_beacon_slot: assert property (s_dbcn |-> d_slot < bw_len)
    else $error("beacon outside beacon window");
  a_data_outside_bw: assert property (s_ddata |-> d_slot >= bw_len)
    else $error("frame in beacon window");
  a_far_outside_bw: assert property (f_valid && f_kind != SMAS_K_BEACON |-> f_slot >= bw_len)
    else $error("far frame in beacon window");
  a_dev_quiet: assert property (d_valid |-> 8'(d_slot - q_start) >= q_len)
    else $error("frame in quiet window");
  a_far_quiet: assert property (f_valid |-> 8'(f_slot - q_start) >= q_len)
    else $error("far frame in quiet window");
  a_resv_member: assert property (s_ddata |-> 8'(d_slot - r_start) >= r_len)
    else $error("frame in foreign reservation");
  a_data_channel: assert property (d_valid |-> d_chan == chan)
    else $error("frame on wrong channel");
  a_rx_awake: assert property (f_valid && f_kind == SMAS_K_BEACON |-> d_rx_on)
    else $error("receiver off at beacon");
  a_far_awake: assert property (s_dbcn |-> f_rx_on)
    else $error("far receiver off at beacon");
  a_ack_pairs: assert property (f_valid && f_kind == SMAS_K_ACK |-> f_seq == imm_seq_reg)
    else $error("ack names wrong frame");
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Bench joining both scheduler ends over the link
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import smas_pkg::*;
  logic        clk = 1'b0, arst_n = 1'b0, en = 1'b1, f_en = 1'b1, f_mst = 1'b0, f_bcn = 1'b0;
  logic        inc = 1'b1, slp = 1'b0, tx_req = 1'b0, bar_req = 1'b0, member = 1'b0;
  logic        promote = 1'b0;
  smas_mode_t  mode = SMAS_MODE_MASTER;
  smas_ackp_t  ackp = SMAS_ACK_NONE;
  logic [11:0] seq = 12'h000, rx_seq;
  logic [7:0]  bw = 8'h02, contention_signal_window = 8'h04, qs = 8'h64, ql = 8'h02, rs = 8'h32, rl = 8'h04;
  logic [7:0]  reserved_signal_window = 8'h01;
  logic [2:0]  rate = 3'h3, prio = 3'h1;
  logic [7:0]  slot_num, f_slot_num, back_bmap, last_slot = 8'h00, bcn_slot = 8'hff;
  logic [3:0]  ch = 4'h5, frag = 4'h0, retry_max = 4'h1, rx_frag;
  logic        sf_start, in_bw, in_rsw, in_dtw, in_csw, rx_on, synced, tx_accept, tx_done;
  logic        tx_fail, rx_data;
  int          num_errors = 0, total_checks = 0, cyc = 0, n_data = 0, n_rx = 0, t0;

  smas_if lnk ();
  smas_device_end #(.SLOT_DURATION_NS(1000)) u_smas_device_end (
    .clk(clk), .arst_n(arst_n), .enable(en), .mode(mode), .promote(promote),
    .chan_sel(ch), .incumbent(inc), .beacon_slots(bw), .own_slot(8'h00), .rsw_slots(reserved_signal_window),
    .csw_slots(contention_signal_window), .quiet_start(qs), .quiet_len(ql), .resv_start(rs), .resv_len(rl),
    .resv_member(member), .sleep_req(slp), .tx_req(tx_req), .bar_req(bar_req),
    .tx_seq(seq), .tx_frag(frag), .tx_ackp(ackp), .tx_rate(rate), .tx_prio(prio),
    .retry_max(retry_max), .slot_num(slot_num), .sf_start(sf_start), .in_bw(in_bw),
    .in_rsw(in_rsw), .in_dtw(in_dtw), .in_csw(in_csw), .rx_on(rx_on), .synced(synced),
    .tx_accept(tx_accept), .tx_done(tx_done), .tx_fail(tx_fail), .back_bmap(back_bmap),
    .lnk(lnk));
  smas_far_end #(.SLOT_DURATION_NS(1000)) u_smas_far_end (
    .clk(clk), .arst_n(arst_n), .enable(f_en), .chan(ch), .is_master(f_mst),
    .beacon_en(f_bcn), .own_slot(8'h01), .bp_len(bw), .csw_slots(contention_signal_window), .quiet_start(qs),
    .quiet_len(ql), .sleep_req(slp), .slot_num(f_slot_num), .rx_data(rx_data),
    .rx_seq(rx_seq), .rx_frag(rx_frag), .lnk(lnk));
  smas_properties u_smas_properties (
    .clk(clk), .arst_n(arst_n), .bw_len(bw), .q_start(qs), .q_len(ql), .r_start(rs),
    .r_len(rl), .chan(ch), .d_valid(lnk.d_valid), .d_kind(lnk.d_kind),
    .d_chan(lnk.d_chan), .d_slot(lnk.d_slot), .d_seq(lnk.d_seq), .d_ackp(lnk.d_ackp),
    .d_hrate(lnk.d_hrate), .d_prate(lnk.d_prate), .d_rx_on(lnk.d_rx_on),
    .f_valid(lnk.f_valid), .f_kind(lnk.f_kind), .f_slot(lnk.f_slot), .f_seq(lnk.f_seq),
    .f_rx_on(lnk.f_rx_on));

  always #5 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (lnk.d_valid === 1'b1 && lnk.d_kind === SMAS_K_DATA) begin
      n_data <= n_data + 1;
      last_slot <= lnk.d_slot;
    end
    if (lnk.d_valid === 1'b1 && lnk.d_kind === SMAS_K_BEACON) begin
      bcn_slot <= lnk.d_slot;
    end
    if (rx_data === 1'b1) begin
      n_rx <= n_rx + 1;
    end
    // Three superframes plus transfers fit well inside this ceiling
    if (cyc == 95000) begin
      num_errors++;
      $display("mismatch at %0t: timeout", $time);
      end_sim();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  task automatic wait_slot(input logic [7:0] s);
    for (int i = 0; i < 30000 && slot_num !== s; i++) @(negedge clk);
  endtask

  // Request is held until the edge that takes it, then the result is awaited
  task automatic send(input logic [11:0] sq, input smas_ackp_t ap, input logic bar);
    @(posedge clk);
    seq <= sq;
    frag <= sq[3:0] + 4'h1;
    ackp <= ap;
    tx_req <= ~bar;
    bar_req <= bar;
    for (int i = 0; i < 3000 && tx_accept !== 1'b1; i++) @(negedge clk);
    @(posedge clk);
    tx_req <= 1'b0;
    bar_req <= 1'b0;
    for (int i = 0; i < 3000 && tx_done !== 1'b1 && tx_fail !== 1'b1; i++) @(negedge clk);
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    wait_slot(8'hff);
    wait_slot(8'h00);
    t0 = cyc;
    @(negedge clk);
    chk(16'(synced), 16'h0000);
    @(posedge clk);
    inc <= 1'b0;
    wait_slot(8'hff);
    wait_slot(8'h00);
    chk(16'(cyc - t0), 16'h6400);
    chk(16'(sf_start), 16'h0001);
    repeat (2) @(negedge clk);
    chk(16'(synced), 16'h0001);
    wait_slot(8'h01);
    chk(16'({in_bw, in_rsw, in_dtw, in_csw}), 16'h0008);
    wait_slot(8'h02);
    chk(16'({in_bw, in_rsw, in_dtw, in_csw}), 16'h0004);
    @(posedge clk);
    mode <= SMAS_MODE_PEER;
    @(negedge clk);
    chk(16'({in_bw, in_rsw, in_dtw, in_csw}), 16'h0002);
    @(posedge clk);
    mode <= SMAS_MODE_MASTER;
    wait_slot(8'h03);
    chk(16'({in_bw, in_rsw, in_dtw, in_csw}), 16'h0002);
    for (int k = 0; k < 2; k++) begin
      send(12'h011 + 12'(k), (k == 0) ? SMAS_ACK_NONE : SMAS_ACK_IMM, 1'b0);
      chk(16'({tx_done, tx_fail}), 16'h0002);
      @(negedge clk);
      chk({rx_frag, rx_seq}, {4'h2 + 4'(k), 12'h011 + 12'(k)});
    end
    send(12'h003, SMAS_ACK_BLOCK, 1'b0);
    send(12'h005, SMAS_ACK_BLOCK, 1'b0);
    send(12'h000, SMAS_ACK_NONE, 1'b1);
    @(negedge clk);
    chk(16'(back_bmap), 16'h0028);
    wait_slot(8'h32);
    send(12'h021, SMAS_ACK_IMM, 1'b0);
    chk(16'(last_slot), 16'h0036);
    wait_slot(8'h64);
    send(12'h022, SMAS_ACK_NONE, 1'b0);
    @(negedge clk);
    chk(16'(last_slot), 16'h0066);
    // Far end silenced so no ack ever returns
    @(posedge clk);
    f_en <= 1'b0;
    retry_max <= 4'h2;
    t0 = n_data;
    send(12'h00a, SMAS_ACK_IMM, 1'b0);
    chk(16'({tx_done, tx_fail}), 16'h0001);
    chk(16'(n_data - t0), 16'h0002);
    chk(16'(n_rx), 16'h0006);
    @(posedge clk);
    f_en <= 1'b1;
    slp <= 1'b1;
    wait_slot(8'hfc);
    chk(16'({in_csw, rx_on}), 16'h0003);
    wait_slot(8'h00);
    chk(16'({sf_start, in_bw, rx_on}), 16'h0007);
    repeat (3) @(negedge clk);
    chk(16'(bcn_slot), 16'h0000);
    @(posedge clk);
    en <= 1'b0;
    mode <= SMAS_MODE_SLAVE;
    f_bcn <= 1'b1;
    f_mst <= 1'b1;
    @(posedge clk);
    en <= 1'b1;
    for (int i = 0; i < 30000 && synced !== 1'b1; i++) @(negedge clk);
    chk(16'(synced), 16'h0001);
    chk(16'(slot_num), 16'(f_slot_num));
    end_sim();
  end
endmodule
`default_nettype wire
